/* pkg/lmac_regs.svh */
`ifndef LMAC_REGS_SVH
`define LMAC_REGS_SVH
`define LMAC_ADDR_LOW_THR  16'h0208
`define LMAC_ADDR_HIGH_THR 16'h0209
`define LMAC_ADDR_SENS     16'h0210
`define LMAC_ADDR_CLK      16'h0212
`define LMAC_ADDR_MIS      16'h0213
`define LMAC_ADDR_ALM      16'h0214
`define LMAC_ADDR_STAT     16'h0215
`define LMAC_LOG_BASE      16'h1000
`define LMAC_LOG_LAST      16'h2FFF
`define LMAC_SENS_HIGH_EN  1
`define LMAC_SENS_LOW_EN   0
`define LMAC_CLK_SEC       1
`define LMAC_CLK_OSC       0
`define LMAC_MIS_START_ON_ALARM      5
`define LMAC_MIS_WRAP      4
`define LMAC_MIS_WIDE      2
`define LMAC_MIS_LOG       0
`define LMAC_CTRL_MASK     8'h03
`define LMAC_MIS_FIXED     2'h3
`define LMAC_ALM_FIXED     3'h7
`define LMAC_STAT_FIXED    2'h3
`define LMAC_BYTE_RST      8'h00
`define LMAC_MIS_RST       6'h00
`endif

/* pkg/lmac_pkg.sv */
package lmac_pkg;
  typedef logic [7:0]  lmac_byte_t;
  typedef logic [15:0] lmac_addr_t;
  typedef enum logic [2:0] {
    LMAC_IDLE  = 3'b000,
    LMAC_DELAY = 3'b001,
    LMAC_WAIT  = 3'b010,
    LMAC_LOG   = 3'b011,
    LMAC_FULL  = 3'b100
  } lmac_state_t;
endpackage

/* rtl/lmac_trip_cmp.sv */
`timescale 1ns/100ps
`default_nettype none
module lmac_trip_cmp (
  input  wire logic                sample_valid,
  input  wire lmac_pkg::lmac_addr_t sample,
  input  wire lmac_pkg::lmac_byte_t low_thr,
  input  wire lmac_pkg::lmac_byte_t high_thr,
  input  wire logic                high_en,
  input  wire logic                low_en,
  output logic                     high_hit,
  output logic                     low_hit
);
  import lmac_pkg::*;
  lmac_byte_t upper;
  // Only the upper byte is compared, so 8- and 16-bit modes alarm alike.
  assign upper    = sample[15:8];
  // Unsigned compare; the byte is offset-coded so no sign handling is needed.
  assign high_hit = sample_valid && high_en && (upper >= high_thr);
  assign low_hit  = sample_valid && low_en && (upper <= low_thr);
endmodule
`default_nettype wire

/* rtl/lmac_log_writer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lmac_regs.svh"
module lmac_log_writer (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic                 restart,
  input  wire logic                 sample_valid,
  input  wire lmac_pkg::lmac_addr_t sample,
  input  wire logic                 wide,
  input  wire logic                 wrap,
  output lmac_pkg::lmac_addr_t      wr_addr_r,
  output lmac_pkg::lmac_byte_t      wr_data_r,
  output logic                      wr_en_r,
  output logic                      full_r
);
  import lmac_pkg::*;
  lmac_addr_t ptr_r;
  lmac_byte_t lsb_r;
  logic       pend_r;

  function automatic lmac_addr_t step(input lmac_addr_t p);
    step = (p == `LMAC_LOG_LAST) ? `LMAC_LOG_BASE : p + 16'h0001;
  endfunction

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r     <= `LMAC_LOG_BASE;
      lsb_r     <= 8'h00;
      pend_r    <= 1'b0;
      wr_en_r   <= 1'b0;
      wr_addr_r <= `LMAC_LOG_BASE;
      wr_data_r <= 8'h00;
      full_r    <= 1'b0;
    end else if (restart) begin
      ptr_r   <= `LMAC_LOG_BASE;
      pend_r  <= 1'b0;
      wr_en_r <= 1'b0;
      full_r  <= 1'b0;
    end else if (pend_r) begin
      // Low byte goes one address above the high byte.
      wr_en_r   <= 1'b1;
      wr_addr_r <= ptr_r;
      wr_data_r <= lsb_r;
      ptr_r     <= step(ptr_r);
      pend_r    <= 1'b0;
      full_r    <= (ptr_r == `LMAC_LOG_LAST) && !wrap;
    end else if (sample_valid && !full_r) begin
      wr_en_r   <= 1'b1;
      wr_addr_r <= ptr_r;
      wr_data_r <= sample[15:8];
      ptr_r     <= step(ptr_r);
      pend_r    <= wide;
      lsb_r     <= sample[7:0];
      full_r    <= (ptr_r == `LMAC_LOG_LAST) && !wrap;
    end else begin
      wr_en_r <= 1'b0;
    end
  end

  sequence wide_taken;
    sample_valid && !full_r && !pend_r && !restart && wide;
  endsequence
  msb_first_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wide_taken |=> wr_en_r && wr_data_r == $past(sample[15:8])
      ##1 wr_en_r && wr_addr_r == $past(wr_addr_r) + 16'h0001)
    else $error("wide sample not stored high byte first");
  restart_base_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    restart |=> ptr_r == `LMAC_LOG_BASE && !pend_r && !full_r && !wr_en_r)
    else $error("log pointer not back at log base");
endmodule
`default_nettype wire

/* rtl/lmac_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lmac_regs.svh"
module lmac_top (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire lmac_pkg::lmac_addr_t reg_addr,
  input  wire logic                 reg_wr,
  input  wire lmac_pkg::lmac_byte_t reg_wdata,
  output lmac_pkg::lmac_byte_t      reg_rdata_r,
  input  wire logic                 cmd_start_mission,
  input  wire logic                 cmd_stop_mission,
  input  wire logic                 cmd_clear_memory,
  input  wire logic                 cmd_forced_conv,
  input  wire logic                 start_delay_done,
  input  wire logic                 sample_tick,
  input  wire logic                 conv_valid,
  input  wire logic                 conv_forced,
  input  wire lmac_pkg::lmac_addr_t conv_result,
  output logic                      oscillator_run_r,
  output logic                      seconds_timebase_select_r,
  output logic                      conv_req_r,
  output logic                      conv_narrow_r,
  output logic                      sample_count_inc_r,
  output logic                      log_wr_en_r,
  output lmac_pkg::lmac_addr_t      log_wr_addr_r,
  output lmac_pkg::lmac_byte_t      log_wr_data_r,
  output logic                      search_alarm_r,
  output logic                      mission_active_r
);
  import lmac_pkg::*;

  lmac_state_t state_r;
  lmac_state_t state_nxt;
  lmac_byte_t  low_thr_r;
  lmac_byte_t  high_thr_r;
  logic [1:0]  sens_r;
  logic [5:0]  mis_r;
  logic        high_trip_flag_r;
  logic        low_trip_flag_r;
  logic        battery_loss_flag_r;
  logic        awaiting_alarm_r;
  logic        log_wiped_r;
  logic        start_ok;
  logic        mission_conv;
  logic        trip_ok;
  logic        high_hit;
  logic        low_hit;
  logic        alarm_evt;
  logic        log_sample;
  logic        log_full;
  lmac_byte_t  rd_mux;

  // Host writes go through here so the mission lock is applied in one place.
  function automatic logic wr_hit(input lmac_addr_t a, input logic locked);
    wr_hit = reg_wr && (reg_addr == a) && !locked;
  endfunction

  assign start_ok     = cmd_start_mission && !cmd_stop_mission && !mission_active_r
                        && mis_r[`LMAC_MIS_LOG];
  assign mission_conv = conv_valid && !conv_forced
                        && (state_r == LMAC_WAIT || state_r == LMAC_LOG);
  // Forced conversions only count between missions, where they may set flags.
  assign trip_ok      = mission_conv || (conv_valid && conv_forced && !mission_active_r);
  assign alarm_evt    = high_hit || low_hit;
  // The alarm that ends the wait is itself logged as the first sample.
  assign log_sample   = mission_conv && (state_r == LMAC_LOG || alarm_evt);

  lmac_trip_cmp u_cmp (
    .sample_valid (trip_ok),
    .sample       (conv_result),
    .low_thr      (low_thr_r),
    .high_thr     (high_thr_r),
    .high_en      (sens_r[`LMAC_SENS_HIGH_EN]),
    .low_en       (sens_r[`LMAC_SENS_LOW_EN]),
    .high_hit     (high_hit),
    .low_hit      (low_hit)
  );

  lmac_log_writer u_log (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .restart      (start_ok),
    .sample_valid (log_sample),
    .sample       (conv_result),
    .wide         (mis_r[`LMAC_MIS_WIDE]),
    .wrap         (mis_r[`LMAC_MIS_WRAP]),
    .wr_addr_r    (log_wr_addr_r),
    .wr_data_r    (log_wr_data_r),
    .wr_en_r      (log_wr_en_r),
    .full_r       (log_full)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LMAC_IDLE: begin
        if (start_ok) begin
          state_nxt = LMAC_DELAY;
        end
      end
      LMAC_DELAY: begin
        if (start_delay_done) begin
          state_nxt = mis_r[`LMAC_MIS_START_ON_ALARM] ? LMAC_WAIT : LMAC_LOG;
        end
      end
      LMAC_WAIT: begin
        if (mission_conv && alarm_evt) begin
          state_nxt = LMAC_LOG;
        end
      end
      LMAC_LOG: begin
        if (log_full) begin
          state_nxt = LMAC_FULL;
        end
      end
      LMAC_FULL: begin
        state_nxt = LMAC_FULL;
      end
      default: begin
        state_nxt = LMAC_IDLE;
      end
    endcase
    if (cmd_stop_mission) begin
      state_nxt = LMAC_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r          <= LMAC_IDLE;
      mission_active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // A full log without wrap keeps the mission open until a stop.
      if (cmd_stop_mission) begin
        mission_active_r <= 1'b0;
      end else if (start_ok) begin
        mission_active_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      low_thr_r  <= `LMAC_BYTE_RST;
      high_thr_r <= `LMAC_BYTE_RST;
      sens_r     <= 2'h0;
      mis_r      <= `LMAC_MIS_RST;
    end else begin
      if (wr_hit(`LMAC_ADDR_LOW_THR, mission_active_r)) begin
        low_thr_r <= reg_wdata;
      end
      if (wr_hit(`LMAC_ADDR_HIGH_THR, mission_active_r)) begin
        high_thr_r <= reg_wdata;
      end
      if (wr_hit(`LMAC_ADDR_SENS, mission_active_r)) begin
        sens_r <= reg_wdata[1:0];
      end
      // Bits 3 and 1 are stored as written; bit 1 must be kept at 0 by the host.
      if (wr_hit(`LMAC_ADDR_MIS, mission_active_r)) begin
        mis_r <= reg_wdata[5:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oscillator_run_r          <= 1'b0;
      seconds_timebase_select_r <= 1'b0;
    end else begin
      if (wr_hit(`LMAC_ADDR_CLK, mission_active_r)) begin
        oscillator_run_r          <= reg_wdata[`LMAC_CLK_OSC];
        seconds_timebase_select_r <= reg_wdata[`LMAC_CLK_SEC];
      end
      // The command wins over a same-cycle write of 0.
      if (start_ok || cmd_forced_conv) begin
        oscillator_run_r <= 1'b1;
      end
    end
  end

  // Battery loss resets to 1: power-on reset is exactly the event it records.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      battery_loss_flag_r <= 1'b1;
      high_trip_flag_r    <= 1'b0;
      low_trip_flag_r     <= 1'b0;
    end else begin
      if (cmd_clear_memory && !mission_active_r) begin
        battery_loss_flag_r <= 1'b0;
        high_trip_flag_r    <= high_hit;
        low_trip_flag_r     <= low_hit;
      end else begin
        high_trip_flag_r <= high_trip_flag_r || high_hit;
        low_trip_flag_r  <= low_trip_flag_r || low_hit;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      awaiting_alarm_r <= 1'b0;
      log_wiped_r      <= 1'b0;
    end else begin
      if (trip_ok && alarm_evt) begin
        awaiting_alarm_r <= 1'b0;
      end else if (start_ok) begin
        awaiting_alarm_r <= mis_r[`LMAC_MIS_START_ON_ALARM];
      end
      if (start_ok) begin
        log_wiped_r <= 1'b0;
      end else if (cmd_clear_memory && !mission_active_r) begin
        log_wiped_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      conv_req_r         <= 1'b0;
      conv_narrow_r      <= 1'b0;
      sample_count_inc_r <= 1'b0;
      search_alarm_r     <= 1'b0;
    end else begin
      // No requests in the full state: conversions stop with the log.
      conv_req_r <= (sample_tick && (state_r == LMAC_WAIT || state_r == LMAC_LOG))
                    || (cmd_forced_conv && !mission_active_r);
      conv_narrow_r      <= sample_tick && (state_r == LMAC_WAIT);
      sample_count_inc_r <= mission_conv && (state_r == LMAC_LOG);
      search_alarm_r     <= battery_loss_flag_r || high_trip_flag_r
                            || low_trip_flag_r;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `LMAC_ADDR_LOW_THR:  rd_mux = low_thr_r;
      `LMAC_ADDR_HIGH_THR: rd_mux = high_thr_r;
      `LMAC_ADDR_SENS:     rd_mux = {6'h00, sens_r} & `LMAC_CTRL_MASK;
      `LMAC_ADDR_CLK:      rd_mux = {6'h00, seconds_timebase_select_r,
                                     oscillator_run_r} & `LMAC_CTRL_MASK;
      `LMAC_ADDR_MIS:      rd_mux = {`LMAC_MIS_FIXED, mis_r};
      `LMAC_ADDR_ALM:      rd_mux = {battery_loss_flag_r, `LMAC_ALM_FIXED, 2'h0,
                                     high_trip_flag_r, low_trip_flag_r};
      `LMAC_ADDR_STAT:     rd_mux = {`LMAC_STAT_FIXED, 1'b0, awaiting_alarm_r,
                                     log_wiped_r, 1'b0, mission_active_r, 1'b0};
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= rd_mux;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence alarm_in_wait;
    state_r == LMAC_WAIT && mission_conv && alarm_evt;
  endsequence
  sequence alarm_logged;
    log_wr_en_r && !sample_count_inc_r && state_r == LMAC_LOG;
  endsequence

  high_trip_a: assert property (
    trip_ok && sens_r[1] && conv_result[15:8] >= high_thr_r |=> high_trip_flag_r)
    else $error("high trip flag not set");
  high_off_a: assert property (
    !high_trip_flag_r && !sens_r[1] |=> !high_trip_flag_r)
    else $error("high trip flag set while disabled");
  low_trip_a: assert property (
    trip_ok && sens_r[0] && conv_result[15:8] <= low_thr_r |=> low_trip_flag_r)
    else $error("low trip flag not set");
  trip_hold_a: assert property (
    mission_active_r && high_trip_flag_r && low_trip_flag_r
      |=> high_trip_flag_r && low_trip_flag_r)
    else $error("trip flag dropped in mission");
  ctrl_zero_a: assert property (
    reg_addr == `LMAC_ADDR_CLK |=> reg_rdata_r[7:2] == 6'h00)
    else $error("clock control high bits not zero");
  write_lock_a: assert property (
    mission_active_r && !cmd_stop_mission |=> $stable(mis_r) && $stable(sens_r))
    else $error("control written during mission");
  osc_start_a: assert property (
    start_ok || cmd_forced_conv |=> oscillator_run_r)
    else $error("oscillator not started by command");
  mis_fixed_a: assert property (
    reg_addr == `LMAC_ADDR_MIS |=> reg_rdata_r[7:6] == 2'h3)
    else $error("mission control bits 7 and 6 not one");
  alarm_start_a: assert property (
    alarm_in_wait and !cmd_stop_mission |=> alarm_logged)
    else $error("start alarm not logged uncounted");
  full_stop_a: assert property (
    state_r == LMAC_FULL |-> mission_active_r ##1 !conv_req_r || cmd_stop_mission)
    else $error("conversion requested with full log");
  bor_hold_a: assert property (
    battery_loss_flag_r && !cmd_clear_memory |=> battery_loss_flag_r)
    else $error("battery loss flag lost");
  search_a: assert property (
    high_trip_flag_r ##1 1'b1 |-> search_alarm_r)
    else $error("alarmed device not searchable");
  wiped_a: assert property (
    start_ok |=> !log_wiped_r && mission_active_r)
    else $error("log wiped bit not cleared at start");
endmodule
`default_nettype wire

/* bench/lmac_conv_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Sensor front end: answers each conversion request two cycles later.
module lmac_conv_model (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic                 conv_req_r,
  input  wire logic                 mission_active_r,
  input  wire lmac_pkg::lmac_addr_t temp_in,
  output logic                      conv_valid,
  output logic                      conv_forced,
  output lmac_pkg::lmac_addr_t      conv_result
);
  import lmac_pkg::*;
  logic req_d1_r;
  logic fc_d1_r;

  // Outside a valid pulse the result toggles, so a stale capture cannot look right.
  // A request made outside a mission can only be a forced one, so it is marked as such.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      req_d1_r    <= 1'b0;
      fc_d1_r     <= 1'b0;
      conv_valid  <= 1'b0;
      conv_forced <= 1'b0;
      conv_result <= 16'h0000;
    end else begin
      req_d1_r    <= conv_req_r;
      fc_d1_r     <= conv_req_r && !mission_active_r;
      conv_valid  <= req_d1_r;
      conv_forced <= fc_d1_r;
      conv_result <= req_d1_r ? temp_in : ~conv_result;
    end
  end
endmodule
`default_nettype wire

/* bench/lmac_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lmac_regs.svh"
module lmac_top_tb;
  import lmac_pkg::*;
  logic       clk_sys = 1'b0;
  logic       arst_n  = 1'b0;
  lmac_addr_t reg_addr = 16'h0000;
  logic       reg_wr = 1'b0;
  lmac_byte_t reg_wdata = 8'h00;
  logic       cmd_start = 1'b0, cmd_stop = 1'b0, cmd_clr = 1'b0, cmd_fc = 1'b0;
  logic       delay_done = 1'b0, tick = 1'b0;
  lmac_addr_t temp_in = 16'h0000;
  logic       conv_valid, conv_forced, conv_req_r, conv_narrow_r, inc_r, wr_en_r;
  logic       osc_r, sec_r, search_r, active_r;
  lmac_addr_t conv_result, wr_addr_r;
  lmac_byte_t reg_rdata_r, wr_data_r;
  int         n_fail = 0;
  int         num_checks = 0;

  always #10 clk_sys = ~clk_sys;

  lmac_top lmac_top_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .cmd_start_mission(cmd_start),
    .cmd_stop_mission(cmd_stop), .cmd_clear_memory(cmd_clr), .cmd_forced_conv(cmd_fc),
    .start_delay_done(delay_done), .sample_tick(tick), .conv_valid(conv_valid),
    .conv_forced(conv_forced), .conv_result(conv_result), .oscillator_run_r(osc_r),
    .seconds_timebase_select_r(sec_r), .conv_req_r(conv_req_r),
    .conv_narrow_r(conv_narrow_r), .sample_count_inc_r(inc_r), .log_wr_en_r(wr_en_r),
    .log_wr_addr_r(wr_addr_r), .log_wr_data_r(wr_data_r), .search_alarm_r(search_r),
    .mission_active_r(active_r));

  lmac_conv_model lmac_conv_model_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .conv_req_r(conv_req_r), .temp_in(temp_in),
    .mission_active_r(active_r),
    .conv_valid(conv_valid), .conv_forced(conv_forced), .conv_result(conv_result));

  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input lmac_addr_t a, input lmac_byte_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input lmac_addr_t a, input lmac_byte_t e);
    @(posedge clk_sys);
    reg_addr <= a;
    @(posedge clk_sys);
    #1;
    chk({8'h00, reg_rdata_r}, {8'h00, e});
  endtask

  // Pulses one command line selected by index for a single cycle.
  task automatic cmd(input int k);
    @(posedge clk_sys);
    cmd_start  <= (k == 0);
    cmd_stop   <= (k == 1);
    cmd_clr    <= (k == 2);
    cmd_fc     <= (k == 3);
    delay_done <= (k == 4);
    @(posedge clk_sys);
    {cmd_start, cmd_stop, cmd_clr, cmd_fc, delay_done} <= 5'h00;
  endtask

  // One sample tick with the given conversion value, then wait for the first log byte.
  task automatic sample(input lmac_addr_t t, input logic expect_wr);
    int i;
    @(posedge clk_sys);
    temp_in <= t;
    tick    <= 1'b1;
    @(posedge clk_sys);
    tick    <= 1'b0;
    for (i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      #1;
      if (wr_en_r === 1'b1) break;
    end
    chk({15'h0000, wr_en_r}, {15'h0000, expect_wr});
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`LMAC_ADDR_ALM, 8'hF0);
    rd(`LMAC_ADDR_STAT, 8'hC0);
    rd(`LMAC_ADDR_MIS, 8'hC0);
    chk({15'h0000, search_r}, 16'h0001);
    rd(16'h0211, 8'h00);
    wr(`LMAC_ADDR_SENS, 8'hFF);
    rd(`LMAC_ADDR_SENS, 8'h03);
    wr(`LMAC_ADDR_CLK, 8'hFE);
    rd(`LMAC_ADDR_CLK, 8'h02);
    chk({14'h0000, osc_r, sec_r}, 16'h0001);
    wr(`LMAC_ADDR_CLK, 8'h01);
    #1;
    chk({14'h0000, osc_r, sec_r}, 16'h0002);
    wr(`LMAC_ADDR_CLK, 8'h00);
    cmd(3);
    #1;
    chk({15'h0000, osc_r}, 16'h0001);
    wr(`LMAC_ADDR_CLK, 8'h00);
    rd(`LMAC_ADDR_ALM, 8'hF3);
    cmd(2);
    rd(`LMAC_ADDR_ALM, 8'h70);
    chk({15'h0000, search_r}, 16'h0000);
    wr(`LMAC_ADDR_LOW_THR, 8'h40);
    wr(`LMAC_ADDR_HIGH_THR, 8'h80);
    wr(`LMAC_ADDR_MIS, 8'h05);
    rd(`LMAC_ADDR_MIS, 8'hC5);
    cmd(0);
    #1;
    chk({14'h0000, active_r, osc_r}, 16'h0003);
    rd(`LMAC_ADDR_STAT, 8'hC2);
    wr(`LMAC_ADDR_SENS, 8'h00);
    wr(`LMAC_ADDR_MIS, 8'h11);
    rd(`LMAC_ADDR_SENS, 8'h03);
    rd(`LMAC_ADDR_MIS, 8'hC5);
    cmd(4);
    sample(16'h8012, 1'b1);
    chk(wr_addr_r, `LMAC_LOG_BASE);
    chk({8'h00, wr_data_r}, 16'h0080);
    chk({15'h0000, inc_r}, 16'h0001);
    @(posedge clk_sys);
    #1;
    chk({wr_en_r, wr_addr_r[14:0]}, 16'h9001);
    chk({8'h00, wr_data_r}, 16'h0012);
    rd(`LMAC_ADDR_ALM, 8'h72);
    sample(16'h40FF, 1'b1);
    chk(wr_addr_r, 16'h1002);
    rd(`LMAC_ADDR_ALM, 8'h73);
    cmd(1);
    #1;
    chk({15'h0000, active_r}, 16'h0000);
    cmd(2);
    rd(`LMAC_ADDR_STAT, 8'hC8);
    @(posedge clk_sys);
    reg_addr <= `LMAC_ADDR_ALM;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    chk({14'h0000, reg_rdata_r[1:0]}, 16'h0000);
    wr(`LMAC_ADDR_MIS, 8'h21);
    cmd(0);
    cmd(4);
    rd(`LMAC_ADDR_STAT, 8'hD2);
    @(posedge clk_sys);
    temp_in <= 16'h5000;
    tick    <= 1'b1;
    @(posedge clk_sys);
    tick    <= 1'b0;
    #1;
    chk({14'h0000, conv_req_r, conv_narrow_r}, 16'h0003);
    sample(16'h5000, 1'b0);
    sample(16'h9000, 1'b1);
    chk(wr_addr_r, `LMAC_LOG_BASE);
    chk({7'h00, wr_data_r, inc_r}, 16'h0120);
    rd(`LMAC_ADDR_STAT, 8'hC2);
    rd(`LMAC_ADDR_ALM, 8'h72);
    cmd(1);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
